//--- logic/scmc_ctrl.sv
/*
  Stop-clock and management-interrupt sideband controller. Synchronises the
  three active-low request pins, runs the power state machine, requests the
  acknowledge transactions and drives unit clock enables and core controls.
  Assumes the bus interface takes ack_req while ack_ready is high and that
  the clock gating cells sit outside, driven by unit_clk_en.
*/
`timescale 1ns/1ps
module scmc_ctrl (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   sys_mgmt_irq_n,
  input  wire logic                   clock_halt_req_n,
  input  wire logic                   doze_req_n,
  input  wire logic                   mgmt_resume,
  input  wire logic                   ack_ready,
  output scmc_pkg::scmc_ack_t         ack_req,
  output scmc_pkg::scmc_core_t        core_ctl,
  output logic [scmc_pkg::SCMC_UCLK_W-1:0] unit_clk_en,
  output scmc_pkg::scmc_pwr_t         pwr_state
);

  // Synchronised request levels, active low
  logic mgmt_sync_n;
  logic halt_sync_n;
  logic doze_sync_n;

  // Whole module state
  typedef struct packed {
    scmc_pkg::scmc_pwr_t  pwr;        // Power state
    logic                 rst_d;      // Reset seen last cycle
    logic                 mgmt_prev;  // Previous synced management level
    logic                 mgmt_pend;  // Management acknowledge owed
    logic                 mgmt_hold;  // Management edge seen outside run
    logic                 grant_pend; // Grant acknowledge owed
    scmc_pkg::scmc_ack_t  ack;        // Acknowledge request
    scmc_pkg::scmc_core_t core;       // Core controls
    logic [scmc_pkg::SCMC_UCLK_W-1:0] uclk; // Unit clock enables
  } scmc_st_t;

  scmc_st_t st;
  scmc_st_t next_st;

  // Management request pin synchroniser; it keeps sampling through reset
  // so that a request held across reset release is seen on the first edge
  scmc_sync #(.RESET_VAL(1'b1)) u_sync_mgmt (
    .core_clk (core_clk),
    .reset    (1'b0),
    .clk_en   (clk_en),
    .async_in (sys_mgmt_irq_n),
    .sync_out (mgmt_sync_n)
  );

  // Stop-clock request pin synchroniser
  scmc_sync #(.RESET_VAL(1'b1)) u_sync_halt (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in (clock_halt_req_n),
    .sync_out (halt_sync_n)
  );

  // Doze request pin synchroniser
  scmc_sync #(.RESET_VAL(1'b1)) u_sync_doze (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in (doze_req_n),
    .sync_out (doze_sync_n)
  );

  // Next-state logic
  always_comb
  begin
    logic mgmt_edge;
    mgmt_edge = 1'b0;
    next_st   = st;
    // Pulses default low; levels carry over
    next_st.rst_d              = 1'b0;
    next_st.mgmt_prev          = ~mgmt_sync_n;
    next_st.core.save_state    = 1'b0;
    next_st.core.fetch_handler = 1'b0;
    // Asserting edge of the synchronised management level
    mgmt_edge = ~mgmt_sync_n & ~st.mgmt_prev;

    // Acknowledge handed off to the bus interface
    // A new one may be raised in the same cycle
    if (st.ack.valid && ack_ready)
    begin
      next_st.ack.valid = 1'b0;
      next_st.ack.code  = scmc_pkg::SCMC_ACK_NONE;
    end

    case (st.pwr)
      scmc_pkg::SCMC_RUN:
      begin
        // Request held through reset release floats the pins
        if (st.rst_d && !mgmt_sync_n)
        begin
          next_st.pwr                = scmc_pkg::SCMC_FLOAT;
          next_st.core.outputs_float = 1'b1;
        end
        else
        begin
          // Accept a fresh edge, or one held over from stop-grant or sleep
          if ((mgmt_edge || st.mgmt_hold) && !st.core.mgmt_operating_mode)
          begin
            next_st.mgmt_hold                = 1'b0;
            next_st.core.save_state          = 1'b1;
            next_st.core.mgmt_operating_mode = 1'b1;
            next_st.core.fetch_handler       = 1'b1;
            next_st.mgmt_pend                = 1'b1;
          end
          else if (mgmt_resume)
          begin
            next_st.core.mgmt_operating_mode = 1'b0;
          end
          // Stop-clock request moves to grant
          if (!halt_sync_n)
          begin
            next_st.pwr        = scmc_pkg::SCMC_GRANT;
            next_st.grant_pend = 1'b1;
            next_st.uclk       = scmc_pkg::SCMC_UCLK_GRNT;
          end
        end
      end
      scmc_pkg::SCMC_GRANT:
      begin
        // Bus and interrupt units keep clocks; snoops and irqs continue
        next_st.core.snoop_en = 1'b1;
        next_st.core.irq_en   = 1'b1;
        // A management edge here is held until the return to run
        if (mgmt_edge && !st.core.mgmt_operating_mode)
        begin
          next_st.mgmt_hold = 1'b1;
        end
        if (halt_sync_n)
        begin
          next_st.pwr  = scmc_pkg::SCMC_RUN;
          next_st.uclk = scmc_pkg::SCMC_UCLK_ALL;
        end
        else if (!doze_sync_n)
        begin
          next_st.pwr           = scmc_pkg::SCMC_SLEEP;
          next_st.uclk          = scmc_pkg::SCMC_UCLK_NONE;
          next_st.core.snoop_en = 1'b0;
          next_st.core.irq_en   = 1'b0;
        end
      end
      scmc_pkg::SCMC_SLEEP:
      begin
        // Only doze release acts while asleep; a management edge is held
        if (mgmt_edge && !st.core.mgmt_operating_mode)
        begin
          next_st.mgmt_hold = 1'b1;
        end
        if (doze_sync_n)
        begin
          next_st.pwr           = scmc_pkg::SCMC_GRANT;
          next_st.uclk          = scmc_pkg::SCMC_UCLK_GRNT;
          next_st.core.snoop_en = 1'b1;
          next_st.core.irq_en   = 1'b1;
        end
      end
      scmc_pkg::SCMC_FLOAT:
      begin
        // Held until the next reset
        // Owed acknowledges are not issued while floating
        next_st.core.outputs_float = 1'b1;
      end
      default:
      begin
        // Unknown code: recover to run
        next_st.pwr = scmc_pkg::SCMC_RUN;
      end
    endcase

    // Issue owed acknowledges, management first, when the slot is free
    // A freed slot is refilled at once, so acknowledges run back to back
    if (!next_st.ack.valid && !next_st.core.outputs_float)
    begin
      if (next_st.mgmt_pend)
      begin
        next_st.ack.valid = 1'b1;
        next_st.ack.code  = scmc_pkg::SCMC_ACK_MGMT;
        next_st.mgmt_pend = 1'b0;
      end
      else if (next_st.grant_pend)
      begin
        next_st.ack.valid  = 1'b1;
        next_st.ack.code   = scmc_pkg::SCMC_ACK_GRANT;
        next_st.grant_pend = 1'b0;
      end
    end
  end

  // Register state; core_clk itself is never gated here
  // Clock enable low freezes every field, synchronisers included
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st                          <= '0;
      st.pwr                      <= scmc_pkg::SCMC_RUN;
      st.rst_d                    <= 1'b1;
      st.uclk                     <= scmc_pkg::SCMC_UCLK_ALL;
      st.core.snoop_en            <= 1'b1;
      st.core.irq_en              <= 1'b1;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign ack_req     = st.ack;
  assign core_ctl    = st.core;
  assign unit_clk_en = st.uclk;
  assign pwr_state   = st.pwr;

endmodule

//--- include/scmc_pkg.sv
/*
  Package for the stop-clock and management-interrupt sideband controller:
  state encodings, acknowledge codes, timing counts and carrier structs.
  Assumes a single core_clk domain at 10 MHz with synchronous reset.
*/
package scmc_pkg;

  // Power state machine, one-hot
  typedef enum logic [3:0] {
    SCMC_RUN   = 4'h1,
    SCMC_GRANT = 4'h2,
    SCMC_SLEEP = 4'h4,
    SCMC_FLOAT = 4'h8
  } scmc_pwr_t;

  // Acknowledge transaction codes placed on the bus request
  localparam logic [1:0] SCMC_ACK_NONE  = 2'h0;
  localparam logic [1:0] SCMC_ACK_MGMT  = 2'h1;
  localparam logic [1:0] SCMC_ACK_GRANT = 2'h2;

  // Synchroniser depth
  localparam int unsigned SCMC_SYNC_DEPTH = 2;

  // Unit clock enable field positions
  localparam int unsigned SCMC_UCLK_CORE = 0;
  localparam int unsigned SCMC_UCLK_BUS  = 1;
  localparam int unsigned SCMC_UCLK_IRQ  = 2;
  localparam int unsigned SCMC_UCLK_W    = 3;

  // Unit clock enable patterns: all on (reset and run), none (sleep), grant
  localparam logic [2:0] SCMC_UCLK_ALL  = 3'h7;
  localparam logic [2:0] SCMC_UCLK_NONE = 3'h0;
  localparam logic [2:0] SCMC_UCLK_GRNT = 3'h6;

  // Acknowledge transaction output to the bus interface
  typedef struct packed {
    logic       valid;     // Request pending
    logic [1:0] code;      // Acknowledge kind
  } scmc_ack_t;

  // Status toward the core
  typedef struct packed {
    logic       mgmt_operating_mode; // Core runs the management handler
    logic       save_state;          // Pulse: save execution state
    logic       fetch_handler;       // Pulse: redirect fetch to handler
    logic       snoop_en;            // Snoops honoured
    logic       irq_en;              // Interrupts serviced
    logic       outputs_float;       // All pins released
  } scmc_core_t;

endpackage

//--- logic/scmc_sync.sv
/*
  Two-flop level synchroniser for one asynchronous sideband pin.
  Assumes core_clk, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module scmc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);

  // Both stages in one packed state
  typedef struct packed {
    logic meta;   // First stage, read only by second
    logic stable; // Second stage
  } scmc_sync_st_t;

  scmc_sync_st_t st;
  scmc_sync_st_t next_st;

  // Shift the pin through two flops
  always_comb
  begin
    next_st        = st;
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  // Register state
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st <= {RESET_VAL, RESET_VAL};
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule

//--- verif/scmc_ctrl_chk.sv
/* Assertions on the scmc_ctrl ports. Assumes a bind from the bench top and clk_en held high. */
`timescale 1ns/1ps
module scmc_ctrl_chk (
  input wire logic                         core_clk,
  input wire logic                         reset,
  input wire logic                         clk_en,
  input wire logic                         sys_mgmt_irq_n,
  input wire logic                         clock_halt_req_n,
  input wire logic                         doze_req_n,
  input wire logic                         mgmt_resume,
  input wire logic                         ack_ready,
  input wire scmc_pkg::scmc_ack_t          ack_req,
  input wire scmc_pkg::scmc_core_t         core_ctl,
  input wire logic [scmc_pkg::SCMC_UCLK_W-1:0] unit_clk_en,
  input wire scmc_pkg::scmc_pwr_t          pwr_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  grant_clk_a: assert property (pwr_state == scmc_pkg::SCMC_GRANT |-> unit_clk_en == 3'h6)
    else $error("grant clock enables wrong");
  sleep_clk_a: assert property (pwr_state == scmc_pkg::SCMC_SLEEP |-> unit_clk_en == 3'h0)
    else $error("sleep clock enables wrong");
  grant_snoop_a: assert property (pwr_state == scmc_pkg::SCMC_GRANT |-> core_ctl.snoop_en && core_ctl.irq_en)
    else $error("grant stopped snoops");
  halt_entry_a: assert property ((pwr_state == scmc_pkg::SCMC_RUN && !clock_halt_req_n && clk_en) [*3]
    |=> pwr_state == scmc_pkg::SCMC_GRANT) else $error("no grant entry");
  halt_exit_a: assert property ((pwr_state == scmc_pkg::SCMC_GRANT && clock_halt_req_n && doze_req_n) [*3]
    |=> pwr_state == scmc_pkg::SCMC_RUN && unit_clk_en == 3'h7) else $error("no run return");
  doze_entry_a: assert property ((pwr_state == scmc_pkg::SCMC_GRANT && !clock_halt_req_n && !doze_req_n) [*3]
    |=> pwr_state == scmc_pkg::SCMC_SLEEP) else $error("no sleep entry");
  doze_exit_a: assert property ((pwr_state == scmc_pkg::SCMC_SLEEP && doze_req_n) [*3]
    |=> pwr_state == scmc_pkg::SCMC_GRANT) else $error("no sleep exit");
  grant_ack_a: assert property (pwr_state == scmc_pkg::SCMC_GRANT && $past(pwr_state) == scmc_pkg::SCMC_RUN
    |-> ##[0:16] (ack_req.valid && ack_req.code == scmc_pkg::SCMC_ACK_GRANT)) else $error("grant ack missing");
  float_hold_a: assert property (pwr_state == scmc_pkg::SCMC_FLOAT
    |-> core_ctl.outputs_float && !ack_req.valid) else $error("float state leaks acks");
  mgmt_entry_a: assert property ($rose(core_ctl.mgmt_operating_mode)
    |-> core_ctl.save_state && core_ctl.fetch_handler ##1 !core_ctl.save_state) else $error("mgmt entry wrong");
  ack_hold_a: assert property (ack_req.valid && !ack_ready |=> ack_req.valid && $stable(ack_req.code))
    else $error("ack dropped early");
endmodule

//--- verif/scmc_chipset_model.sv
/* Chipset-side model: drives the request pins, accepts acks. Assumes core_clk from the bench. */
`timescale 1ns/1ps
module scmc_chipset_model (
  input  wire logic core_clk,
  input  wire logic mgmt_want,
  input  wire logic halt_want,
  input  wire logic doze_want,
  input  wire logic slow,
  output logic      sys_mgmt_irq_n,
  output logic      clock_halt_req_n,
  output logic      doze_req_n,
  output logic      ack_ready
);
  logic [1:0] tick = 2'h0; // Pacing count for slow acceptance
  // Pins follow requests with no tie to the clock edge
  assign #1 sys_mgmt_irq_n = ~mgmt_want;
  assign #1 clock_halt_req_n = ~halt_want;
  assign #1 doze_req_n = ~doze_want;
  initial ack_ready = 1'b0;
  // Slow mode accepts one cycle in four
  always @(posedge core_clk)
  begin
    tick <= tick + 2'h1;
    ack_ready <= #1 ~slow | (tick == 2'h3);
  end
endmodule

//--- verif/scmc_ctrl_tb.sv
/* Bench for scmc_ctrl. Assumes the chipset model and the checker. */
`timescale 1ns/1ps
module scmc_ctrl_tb;
  logic                 core_clk = 1'b0; // 10 MHz clock
  logic                 reset = 1'b1;    // Held 5 cycles
  logic                 clk_en = 1'b1;   // Always running
  logic                 mgmt_resume = 1'b0;
  logic                 mgmt_want = 1'b0, halt_want = 1'b0, doze_want = 1'b0, slow = 1'b0;
  logic                 sys_mgmt_irq_n, clock_halt_req_n, doze_req_n, ack_ready;
  scmc_pkg::scmc_ack_t  ack_req;
  scmc_pkg::scmc_core_t core_ctl;
  logic [2:0]           unit_clk_en;
  scmc_pkg::scmc_pwr_t  pwr_state;
  int                   errors = 0, num_checks = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  scmc_chipset_model scmc_chipset_model_inst (.core_clk(core_clk), .mgmt_want(mgmt_want), .halt_want(halt_want),
    .doze_want(doze_want), .slow(slow), .sys_mgmt_irq_n(sys_mgmt_irq_n), .clock_halt_req_n(clock_halt_req_n),
    .doze_req_n(doze_req_n), .ack_ready(ack_ready));
  scmc_ctrl scmc_ctrl_inst (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .sys_mgmt_irq_n(sys_mgmt_irq_n),
    .clock_halt_req_n(clock_halt_req_n), .doze_req_n(doze_req_n), .mgmt_resume(mgmt_resume),
    .ack_ready(ack_ready), .ack_req(ack_req), .core_ctl(core_ctl), .unit_clk_en(unit_clk_en), .pwr_state(pwr_state));
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [5:0] e, input logic [5:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Stop-clock with a slow acceptor, then release
  task automatic t_halt;
    slow = 1'b1;
    halt_want = 1'b1;
    step(3);
    chk("pwr", scmc_pkg::SCMC_GRANT, pwr_state);
    chk("uclk", 3'h6, unit_clk_en);
    chk("ack", {1'b1, scmc_pkg::SCMC_ACK_GRANT}, ack_req);
    chk("snoop", 2'h3, {core_ctl.snoop_en, core_ctl.irq_en});
    for (int i = 0; i < 8 && ack_req.valid !== 1'b0; i++) step(1);
    chk("ack", 3'h0, ack_req);
    halt_want = 1'b0;
    slow = 1'b0;
    step(3);
    chk("pwr", scmc_pkg::SCMC_RUN, pwr_state);
    chk("uclk", 3'h7, unit_clk_en);
  endtask
  // Sleep entered from grant and left again
  task automatic t_sleep;
    halt_want = 1'b1;
    step(3);
    doze_want = 1'b1;
    step(3);
    chk("pwr", scmc_pkg::SCMC_SLEEP, pwr_state);
    chk("uclk", 3'h0, unit_clk_en);
    doze_want = 1'b0;
    step(3);
    chk("pwr", scmc_pkg::SCMC_GRANT, pwr_state);
    chk("uclk", 3'h6, unit_clk_en);
    halt_want = 1'b0;
    mgmt_want = 1'b1;
    step(4);
    chk("mode", 3'h7, core_ctl[5:3]);
    mgmt_want = 1'b0;
    mgmt_resume = 1'b1;
    step(1);
    mgmt_resume = 1'b0;
    chk("mode", 3'h0, core_ctl[5:3]);
    step(3);
  endtask
  // Management entry, a refused repeat, then resume
  task automatic t_mgmt;
    mgmt_want = 1'b1;
    step(3);
    chk("mode", 3'h7, core_ctl[5:3]);
    chk("ack", {1'b1, scmc_pkg::SCMC_ACK_MGMT}, ack_req);
    step(1);
    chk("mode", 3'h4, core_ctl[5:3]);
    mgmt_want = 1'b0;
    step(2);
    mgmt_want = 1'b1;
    step(3);
    chk("mode", 3'h4, core_ctl[5:3]);
    mgmt_resume = 1'b1;
    step(1);
    mgmt_resume = 1'b0;
    mgmt_want = 1'b0;
    chk("mode", 3'h0, core_ctl[5:3]);
    step(3);
  endtask
  // Both requests at once: management ack goes first
  task automatic t_both;
    mgmt_want = 1'b1;
    halt_want = 1'b1;
    step(3);
    chk("ack", {1'b1, scmc_pkg::SCMC_ACK_MGMT}, ack_req);
    for (int i = 0; i < 4 && ack_req !== {1'b1, scmc_pkg::SCMC_ACK_GRANT}; i++) step(1);
    chk("ack", {1'b1, scmc_pkg::SCMC_ACK_GRANT}, ack_req);
    halt_want = 1'b0;
    mgmt_want = 1'b0;
    step(3);
    chk("pwr", scmc_pkg::SCMC_RUN, pwr_state);
    mgmt_resume = 1'b1;
    step(1);
    mgmt_resume = 1'b0;
    chk("mode", 3'h0, core_ctl[5:3]);
  endtask
  // Request held across reset release floats the pins until a new reset
  task automatic t_float;
    mgmt_want = 1'b1;
    reset = 1'b1;
    step(5);
    reset = 1'b0;
    step(1);
    chk("pwr", scmc_pkg::SCMC_FLOAT, pwr_state);
    chk("ctl", 6'h07, core_ctl);
    mgmt_want = 1'b0;
    halt_want = 1'b1;
    step(4);
    chk("pwr", scmc_pkg::SCMC_FLOAT, pwr_state);
    chk("ack", 3'h0, ack_req);
    halt_want = 1'b0;
    reset = 1'b1;
    step(5);
    reset = 1'b0;
    step(1);
    chk("pwr", scmc_pkg::SCMC_RUN, pwr_state);
    chk("ctl", 6'h06, core_ctl);
    chk("uclk", 3'h7, unit_clk_en);
  endtask
  // Main sequence
  initial
  begin
    step(5);
    reset = 1'b0;
    step(1);
    chk("pwr", scmc_pkg::SCMC_RUN, pwr_state);
    chk("ctl", 6'h06, core_ctl);
    t_halt();
    t_sleep();
    t_mgmt();
    t_both();
    t_float();
    end_of_test();
  end
endmodule
bind scmc_ctrl scmc_ctrl_chk scmc_ctrl_chk_inst (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .sys_mgmt_irq_n(sys_mgmt_irq_n), .clock_halt_req_n(clock_halt_req_n), .doze_req_n(doze_req_n),
  .mgmt_resume(mgmt_resume), .ack_ready(ack_ready), .ack_req(ack_req), .core_ctl(core_ctl),
  .unit_clk_en(unit_clk_en), .pwr_state(pwr_state));
